// ---- design/cfgdec_pkg.sv ----
// Purpose: shared constants and types of the configuration cycle decoder
// Assumes: one clock clk_sys, synchronous active-low reset rstn
// Notes: the selector and window sit at fixed processor i/o addresses
//
// Operation
// - bus zero: decode device field locally
// - bus zero, foreign device: forward to hub link
// - answer as devices 0, 1, 2, 3, 6 and 7 on bus zero
// - bus equals secondary: graphics port type 0
// - bus in (secondary, subordinate]: graphics type 1
// - bus outside graphics range: hub link type 1
// - type 0 idsel one-hot, device 0 on line 16
// - device above 15: no idsel, record master abort
// - device field onto address bits 15:11, except graphics type 0 (zero there)
// - function field onto address bits 10:8
// - ignore internal devices when function nonzero
// - register field onto address bits 7:2
// - selector layout: bus, device, function, register
// - enable set: window access becomes configuration
// - window is 32-bit read/write, follows selector
// - selector only dword; narrower accesses pass through
// - selector bit 31 enables configuration space
package cfgdec_pkg;
  // processor i/o addresses of the two registers
  localparam logic [15:0] CFGDEC_SEL_ADDR = 16'h0cf8;
  localparam logic [15:0] CFGDEC_WIN_ADDR = 16'h0cfc;
  // reset values
  localparam logic [31:0] CFGDEC_SEL_RESET = 32'h0000_0000;
  localparam logic [31:0] CFGDEC_WIN_RESET = 32'h0000_0000;
  // selector field positions
  localparam int CFGDEC_ENA_BIT = 31;
  localparam int CFGDEC_BUS_HI = 23;
  localparam int CFGDEC_BUS_LO = 16;
  localparam int CFGDEC_DEV_HI = 15;
  localparam int CFGDEC_DEV_LO = 11;
  localparam int CFGDEC_FUN_HI = 10;
  localparam int CFGDEC_FUN_LO = 8;
  localparam int CFGDEC_REG_HI = 7;
  localparam int CFGDEC_REG_LO = 2;
  // writable bits of the selector: enable plus bus/device/function/register
  localparam logic [31:0] CFGDEC_SEL_MASK = 32'h80ff_fffc;
  // full dword byte enables
  localparam logic [3:0] CFGDEC_BE_DWORD = 4'hf;
  // internal device numbers of the memory hub
  localparam logic [4:0] CFGDEC_DEV_HOSTHUB = 5'h00;
  localparam logic [4:0] CFGDEC_DEV_GFXBR = 5'h01;
  localparam logic [4:0] CFGDEC_DEV_INT2 = 5'h02;
  localparam logic [4:0] CFGDEC_DEV_INT3 = 5'h03;
  localparam logic [4:0] CFGDEC_DEV_INT6 = 5'h06;
  localparam logic [4:0] CFGDEC_DEV_INT7 = 5'h07;
  // highest device reachable by a graphics idsel line
  localparam logic [4:0] CFGDEC_DEV_IDSEL_MAX = 5'h0f;
  // configuration cycle type codes in address bits 1:0
  localparam logic [1:0] CFGDEC_TYPE0 = 2'h0;
  localparam logic [1:0] CFGDEC_TYPE1 = 2'h1;
  // read data returned for ignored or aborted cycles
  localparam logic [31:0] CFGDEC_ABORT_DATA = 32'hffff_ffff;
  // bus zero
  localparam logic [7:0] CFGDEC_BUS_ZERO = 8'h00;

  // where a processor i/o access is sent
  typedef enum logic [2:0] {
    CFGDEC_RT_PIO,
    CFGDEC_RT_SEL,
    CFGDEC_RT_INT,
    CFGDEC_RT_IGN,
    CFGDEC_RT_HL,
    CFGDEC_RT_GP
  } cfgdec_route_t;

  // transfer sequencer states
  typedef enum logic [1:0] {
    CFGDEC_ST_IDLE,
    CFGDEC_ST_BUSY,
    CFGDEC_ST_ACK
  } cfgdec_state_t;
endpackage

// ---- design/cfgdec_route.sv ----
// Purpose: combinational routing of one processor i/o access
// Assumes: selector value already registered in the caller
// Notes: pure decode, no state; the caller registers all results
module cfgdec_route
(
  input wire logic [31:0] sel,
  input wire logic [15:0] io_addr,
  input wire logic [3:0] io_be,
  input wire logic [7:0] sec_bus,
  input wire logic [7:0] sub_bus,
  output cfgdec_pkg::cfgdec_route_t route,
  output logic [23:0] hl_addr,
  output logic [31:0] gp_addr,
  output logic gp_no_idsel
);
  import cfgdec_pkg::*;

  // internal device numbers of the hub itself
  function automatic logic is_internal(input logic [4:0] dev);
    is_internal = (dev == CFGDEC_DEV_HOSTHUB) || (dev == CFGDEC_DEV_GFXBR)
      || (dev == CFGDEC_DEV_INT2) || (dev == CFGDEC_DEV_INT3)
      || (dev == CFGDEC_DEV_INT6) || (dev == CFGDEC_DEV_INT7);
  endfunction

  // selector fields
  wire logic [7:0] bus = sel[CFGDEC_BUS_HI:CFGDEC_BUS_LO];
  wire logic [4:0] dev = sel[CFGDEC_DEV_HI:CFGDEC_DEV_LO];
  wire logic [2:0] fun = sel[CFGDEC_FUN_HI:CFGDEC_FUN_LO];
  wire logic [5:0] regn = sel[CFGDEC_REG_HI:CFGDEC_REG_LO];
  // address classes
  wire logic hit_sel = (io_addr == CFGDEC_SEL_ADDR) && (io_be == CFGDEC_BE_DWORD);
  wire logic hit_win = (io_addr == CFGDEC_WIN_ADDR) && sel[CFGDEC_ENA_BIT];
  // bus classes
  wire logic bus0 = (bus == CFGDEC_BUS_ZERO);
  wire logic gp_t0 = !bus0 && (bus == sec_bus);
  wire logic gp_t1 = !bus0 && (bus > sec_bus) && (bus <= sub_bus);
  wire logic own = bus0 && is_internal(dev);
  // idsel line, zero above device 15
  wire logic [15:0] idsel = (dev > CFGDEC_DEV_IDSEL_MAX) ? 16'h0000 : (16'h0001 << dev[3:0]);

  assign gp_no_idsel = dev > CFGDEC_DEV_IDSEL_MAX;
  // hub link: bus, device, function, register, type
  assign hl_addr = {bus, dev, fun, regn, (bus0 ? CFGDEC_TYPE0 : CFGDEC_TYPE1)};
  // graphics port: idsel form for type 0, bus/device form for type 1
  assign gp_addr = gp_t0 ? {idsel, 5'h00, fun, regn, CFGDEC_TYPE0}
                         : {8'h00, bus, dev, fun, regn, CFGDEC_TYPE1};

  // priority: selector, plain i/o, internal, graphics, hub link
  always_comb
  begin
    if (hit_sel)
      route = CFGDEC_RT_SEL;
    else if (!hit_win)
      route = CFGDEC_RT_PIO;
    else if (own)
      route = (fun == 3'h0) ? CFGDEC_RT_INT : CFGDEC_RT_IGN;
    else if (gp_t0 || gp_t1)
      route = CFGDEC_RT_GP;
    else
      route = CFGDEC_RT_HL;
  end
endmodule

// ---- design/cfgdec_top.sv ----
// Purpose: processor i/o side of the configuration cycle decoder
// Assumes: all ports are on clk_sys; targets answer with a one-cycle ack
// Notes: one access at a time; io_req is ignored until io_ack has pulsed
module cfgdec_top
(
  input wire logic clk_sys,
  input wire logic rstn,
  // processor i/o access
  input wire logic io_req,
  input wire logic io_wr,
  input wire logic [15:0] io_addr,
  input wire logic [3:0] io_be,
  input wire logic [31:0] io_wdata,
  output logic io_ack,
  output logic [31:0] io_rdata,
  // bus numbers held by the graphics bridge function
  input wire logic [7:0] sec_bus,
  input wire logic [7:0] sub_bus,
  // shared cycle attributes towards every target
  output logic cyc_wr,
  output logic [3:0] cyc_be,
  output logic [31:0] cyc_wdata,
  // internal hub devices
  output logic int_req,
  output logic [4:0] int_dev,
  output logic [5:0] int_reg,
  input wire logic int_ack,
  input wire logic [31:0] int_rdata,
  // downstream hub link configuration cycle
  output logic hl_req,
  output logic [23:0] hl_addr,
  input wire logic hl_ack,
  input wire logic [31:0] hl_rdata,
  // graphics / secondary pci port configuration cycle
  output logic gp_req,
  output logic [31:0] gp_addr,
  input wire logic gp_ack,
  input wire logic [31:0] gp_rdata,
  output logic gp_mabort,
  // plain i/o pass-through to the primary segment
  output logic pio_req,
  output logic [15:0] pio_addr,
  input wire logic pio_ack,
  input wire logic [31:0] pio_rdata
);
  import cfgdec_pkg::*;

  // the processor is held to one access at a time, so a selector write can
  // never race a window access that still uses the old selector contents
  // hazard: a target that never acks stalls the port; there is no timeout

  // registers
  logic [31:0] sel_ff; // target selector
  logic [31:0] nxt_sel;
  cfgdec_state_t state_ff; // sequencer state
  cfgdec_state_t nxt_state;
  cfgdec_route_t route_ff; // route of the access in flight
  logic abort_ff; // graphics type 0 with no idsel in flight
  logic io_ack_ff;
  logic [31:0] io_rdata_ff;
  logic [31:0] nxt_rdata;
  logic cyc_wr_ff;
  logic [3:0] cyc_be_ff;
  logic [31:0] cyc_wdata_ff;
  logic int_req_ff;
  logic [4:0] int_dev_ff;
  logic [5:0] int_reg_ff;
  logic hl_req_ff;
  logic [23:0] hl_addr_ff;
  logic gp_req_ff;
  logic [31:0] gp_addr_ff;
  logic gp_mabort_ff;
  logic pio_req_ff;
  logic [15:0] pio_addr_ff;

  // decoder results
  cfgdec_route_t dec_route;
  logic [23:0] dec_hl_addr;
  logic [31:0] dec_gp_addr;
  logic dec_no_idsel;

  // routing decode of the current selector and access
  cfgdec_route u_route (
    .sel(sel_ff),
    .io_addr(io_addr),
    .io_be(io_be),
    .sec_bus(sec_bus),
    .sub_bus(sub_bus),
    .route(dec_route),
    .hl_addr(dec_hl_addr),
    .gp_addr(dec_gp_addr),
    .gp_no_idsel(dec_no_idsel)
  );

  // access accepted only while idle
  // a request that arrives while busy is dropped without an answer, so the
  // processor side must wait for io_ack before it asks again
  wire logic take = io_req && (state_ff == CFGDEC_ST_IDLE);
  // start strobes per target
  wire logic start_int = take && (dec_route == CFGDEC_RT_INT);
  wire logic start_hl = take && (dec_route == CFGDEC_RT_HL);
  wire logic start_gp = take && (dec_route == CFGDEC_RT_GP);
  wire logic start_pio = take && (dec_route == CFGDEC_RT_PIO);
  // selector and ignored accesses finish locally
  wire logic local_done = take && ((dec_route == CFGDEC_RT_SEL) || (dec_route == CFGDEC_RT_IGN));
  // the addressed target has answered
  // only the port that was started can end the access; a stray ack from
  // another port is ignored here
  wire logic tgt_ack = (route_ff == CFGDEC_RT_INT) ? int_ack
                     : (route_ff == CFGDEC_RT_HL) ? hl_ack
                     : (route_ff == CFGDEC_RT_GP) ? gp_ack
                     : (route_ff == CFGDEC_RT_PIO) ? pio_ack
                     : 1'b0;
  wire logic busy_done = (state_ff == CFGDEC_ST_BUSY) && tgt_ack;
  // reserved selector bits never store a one
  wire logic sel_wr = take && io_wr && (dec_route == CFGDEC_RT_SEL);
  wire logic [31:0] sel_wval = io_wdata & CFGDEC_SEL_MASK;

  // next selector value
  // reserved bits are cleared at write time, so reads need no masking
  always_comb
  begin
    nxt_sel = sel_ff;
    if (sel_wr)
      nxt_sel = sel_wval;
  end

  // read data: selector locally, target data when it answers
  // a write still loads io_rdata from the target; the processor ignores it
  always_comb
  begin
    nxt_rdata = io_rdata_ff;
    if (take && (dec_route == CFGDEC_RT_SEL))
      nxt_rdata = sel_ff;
    else if (take && (dec_route == CFGDEC_RT_IGN))
      nxt_rdata = CFGDEC_ABORT_DATA;
    else if (busy_done)
    begin
      case (route_ff)
        CFGDEC_RT_INT: nxt_rdata = int_rdata;
        CFGDEC_RT_HL: nxt_rdata = hl_rdata;
        CFGDEC_RT_GP: nxt_rdata = abort_ff ? CFGDEC_ABORT_DATA : gp_rdata;
        CFGDEC_RT_PIO: nxt_rdata = pio_rdata;
        default: nxt_rdata = io_rdata_ff;
      endcase
    end
  end

  // sequencer: idle, waiting on a target, acknowledging
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      CFGDEC_ST_IDLE:
      begin
        if (local_done)
          nxt_state = CFGDEC_ST_ACK;
        else if (take)
          nxt_state = CFGDEC_ST_BUSY;
      end
      CFGDEC_ST_BUSY:
      begin
        // no timeout: a target that never answers stalls the processor
        if (tgt_ack)
          nxt_state = CFGDEC_ST_ACK;
      end
      // one cycle of acknowledge, then ready for the next access
      CFGDEC_ST_ACK: nxt_state = CFGDEC_ST_IDLE;
      default: nxt_state = CFGDEC_ST_IDLE;
    endcase
  end

  // selector, state and processor answer
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      sel_ff <= CFGDEC_SEL_RESET;
      state_ff <= CFGDEC_ST_IDLE;
      io_ack_ff <= 1'b0;
      io_rdata_ff <= CFGDEC_WIN_RESET;
    end
    else
    begin
      sel_ff <= nxt_sel;
      state_ff <= nxt_state;
      io_ack_ff <= (nxt_state == CFGDEC_ST_ACK);
      io_rdata_ff <= nxt_rdata;
    end
  end

  // cycle attributes captured at acceptance
  // the abort flag is decided here, while the decode still sees the same
  // selector that produced the graphics address
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      route_ff <= CFGDEC_RT_PIO;
      abort_ff <= 1'b0;
      cyc_wr_ff <= 1'b0;
      cyc_be_ff <= 4'h0;
      cyc_wdata_ff <= 32'h0000_0000;
    end
    else if (take)
    begin
      route_ff <= dec_route;
      abort_ff <= dec_no_idsel && (dec_route == CFGDEC_RT_GP) && (dec_gp_addr[1:0] == CFGDEC_TYPE0);
      cyc_wr_ff <= io_wr;
      cyc_be_ff <= io_be;
      cyc_wdata_ff <= io_wdata;
    end
  end

  // internal device request, held until its ack
  // bus and function need not travel: internal targets are bus zero, function zero
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      int_req_ff <= 1'b0;
      int_dev_ff <= 5'h00;
      int_reg_ff <= 6'h00;
    end
    else if (start_int)
    begin
      int_req_ff <= 1'b1;
      int_dev_ff <= sel_ff[CFGDEC_DEV_HI:CFGDEC_DEV_LO];
      int_reg_ff <= sel_ff[CFGDEC_REG_HI:CFGDEC_REG_LO];
    end
    else if (int_ack)
      int_req_ff <= 1'b0;
  end

  // hub link request, held until its ack
  // the cycle type is already folded into the low address bits by the decode
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      hl_req_ff <= 1'b0;
      hl_addr_ff <= 24'h00_0000;
    end
    else if (start_hl)
    begin
      hl_req_ff <= 1'b1;
      hl_addr_ff <= dec_hl_addr;
    end
    else if (hl_ack)
      hl_req_ff <= 1'b0;
  end

  // graphics port request, held until its ack; abort pulse on completion
  // the abort pulse lines up with io_ack so status and answer are seen together
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      gp_req_ff <= 1'b0;
      gp_addr_ff <= 32'h0000_0000;
      gp_mabort_ff <= 1'b0;
    end
    else
    begin
      gp_mabort_ff <= busy_done && (route_ff == CFGDEC_RT_GP) && abort_ff;
      if (start_gp)
      begin
        gp_req_ff <= 1'b1;
        gp_addr_ff <= dec_gp_addr;
      end
      else if (gp_ack)
        gp_req_ff <= 1'b0;
    end
  end

  // plain i/o pass-through, held until its ack
  // byte and word selector accesses also land here, address unchanged
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      pio_req_ff <= 1'b0;
      pio_addr_ff <= 16'h0000;
    end
    else if (start_pio)
    begin
      pio_req_ff <= 1'b1;
      pio_addr_ff <= io_addr;
    end
    else if (pio_ack)
      pio_req_ff <= 1'b0;
  end

  // outputs straight from flip-flops
  // nothing is decoded on the way out, so the ports never glitch
  assign io_ack = io_ack_ff;
  assign io_rdata = io_rdata_ff;
  assign cyc_wr = cyc_wr_ff;
  assign cyc_be = cyc_be_ff;
  assign cyc_wdata = cyc_wdata_ff;
  assign int_req = int_req_ff;
  assign int_dev = int_dev_ff;
  assign int_reg = int_reg_ff;
  assign hl_req = hl_req_ff;
  assign hl_addr = hl_addr_ff;
  assign gp_req = gp_req_ff;
  assign gp_addr = gp_addr_ff;
  assign gp_mabort = gp_mabort_ff;
  assign pio_req = pio_req_ff;
  assign pio_addr = pio_addr_ff;
endmodule

// ---- tb/cfgdec_asserts.sv ----
// Purpose: concurrent checks on the ports of the configuration cycle decoder
// Assumes: one clock clk_sys, synchronous active-low reset rstn
// Notes: bound to every cfgdec_top instance; watches design ports only, inputs and outputs
module cfgdec_asserts
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic io_ack,
  input wire logic [7:0] sec_bus,
  input wire logic [7:0] sub_bus,
  input wire logic int_req,
  input wire logic int_ack,
  input wire logic hl_req,
  input wire logic [23:0] hl_addr,
  input wire logic hl_ack,
  input wire logic gp_req,
  input wire logic [31:0] gp_addr,
  input wire logic gp_ack,
  input wire logic gp_mabort,
  input wire logic pio_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import cfgdec_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // field views of the hub link and graphics addresses
  logic [7:0] hl_bus;
  logic [4:0] hl_dev;
  logic [7:0] gp_bus;
  assign hl_bus = hl_addr[23:16];
  assign hl_dev = hl_addr[15:11];
  assign gp_bus = gp_addr[23:16];

  chk_ack_pulse: assert property (io_ack |=> !io_ack)
    else $error("io_ack held longer than one cycle");
  chk_one_target: assert property ($onehot0({int_req, hl_req, gp_req, pio_req}))
    else $error("more than one target requested");
  chk_idsel_onehot: assert property (gp_req && gp_addr[1:0] == CFGDEC_TYPE0 |-> $onehot0(gp_addr[31:16]))
    else $error("graphics idsel not one-hot");
  chk_mabort_cause: assert property (gp_mabort |-> io_ack && $past(gp_ack) && $past(gp_addr[31:16]) == 16'h0000)
    else $error("master abort without an idsel-less cycle");
  chk_hl_type: assert property (hl_req |-> hl_addr[1:0] == ((hl_bus == CFGDEC_BUS_ZERO) ? CFGDEC_TYPE0 : CFGDEC_TYPE1))
    else $error("hub link cycle type wrong");
  chk_hl_foreign: assert property (hl_req && hl_bus == 8'h00 |-> !(hl_dev inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h06, 5'h07}))
    else $error("internal device forwarded to hub link");
  chk_gp_range: assert property (gp_req && gp_addr[1:0] == CFGDEC_TYPE1 |-> gp_bus > sec_bus && gp_bus <= sub_bus)
    else $error("graphics type 1 bus out of range");
  chk_hl_range: assert property (hl_req && hl_bus != 8'h00 |-> hl_bus < sec_bus || hl_bus > sub_bus)
    else $error("graphics bus range sent to hub link");
  chk_gp_drop: assert property (gp_req && gp_ack |=> !gp_req && io_ack)
    else $error("graphics answer not returned");
  chk_hl_answer: assert property ($rose(hl_req) |-> ##[1:20] io_ack)
    else $error("hub link access not answered");
  // main scenarios
  cov_mabort: cover property (gp_mabort);
  cov_int: cover property (int_req && int_ack);
  cov_hl_type1: cover property (hl_req && hl_ack && hl_addr[1:0] == CFGDEC_TYPE1);
endmodule
bind cfgdec_top cfgdec_asserts cfgdec_asserts_inst (.clk_sys(clk_sys), .rstn(rstn), .io_ack(io_ack),
  .sec_bus(sec_bus), .sub_bus(sub_bus), .int_req(int_req), .int_ack(int_ack), .hl_req(hl_req),
  .hl_addr(hl_addr), .hl_ack(hl_ack), .gp_req(gp_req), .gp_addr(gp_addr), .gp_ack(gp_ack),
  .gp_mabort(gp_mabort), .pio_req(pio_req));

// ---- tb/cfgdec_target_model.sv ----
// Purpose: behavioural target that answers one request port of the decoder
// Assumes: request is a level held until ack; ack is a one-cycle pulse
// Notes: DLY sets the answer delay; DATA defaults to DLY + 1 in every nibble
module cfgdec_target_model #(
  parameter int DLY = 0,
  parameter logic [31:0] DATA = {8{4'(DLY + 1)}}
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic req,
  output logic ack,
  output logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // wait DLY cycles, pulse ack once, then rearm in the cycle after the pulse
  always @(posedge clk_sys)
  begin
    if (!rstn || !req || ack)
    begin
      ack <= 1'b0;
      cnt <= 0;
    end
    else if (cnt == DLY)
      ack <= 1'b1;
    else
      cnt <= cnt + 1;
  end
  // released data shows the inverse so a stale capture never matches
  assign rdata = ack ? DATA : ~DATA;
endmodule

// ---- tb/config_cycle_decoder_tb.sv ----
// Purpose: self-checking bench for the configuration cycle decoder
// Assumes: secondary bus 5, subordinate bus 8, renumbered to 10/10 near the end
// Notes: table rows program the selector then read the window
module config_cycle_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cfgdec_pkg::*;
  typedef struct {logic [31:0] sel; logic [2:0] kind; logic [31:0] addr; logic [31:0] rd;} cfgdec_row_t;
  logic clk_sys, rstn, io_req, io_wr, io_ack, cyc_wr, int_req, int_ack, hl_req, hl_ack;
  logic gp_req, gp_ack, gp_mabort, pio_req, pio_ack;
  logic [15:0] io_addr, pio_addr;
  logic [3:0] io_be, cyc_be;
  logic [31:0] io_wdata, io_rdata, cyc_wdata, int_rdata, hl_rdata, gp_rdata, gp_addr, pio_rdata;
  logic [7:0] sec_bus, sub_bus;
  logic [4:0] int_dev;
  logic [5:0] int_reg;
  logic [23:0] hl_addr;
  // captured per access: target kind (0 int, 1 hl, 2 gp, 3 pio, 4 none)
  logic [2:0] kind;
  logic [31:0] seen, rd;
  logic mab;
  int bad_count = 0;
  int cmp_count = 0;
  // selector, target, address seen there, read data
  cfgdec_row_t rows [11] = '{
    '{32'h8000_0040, 3'h0, 32'h0000_0010, 32'h1111_1111},
    '{32'h8000_3804, 3'h0, 32'h0000_01c1, 32'h1111_1111},
    '{32'hff00_0a03, 3'h4, 32'h0000_0000, 32'hffff_ffff},
    '{32'h8000_2314, 3'h1, 32'h0000_2314, 32'h2222_2222},
    '{32'h8005_110c, 3'h2, 32'h0004_010c, 32'h3333_3333},
    '{32'h8005_7800, 3'h2, 32'h8000_0000, 32'h3333_3333},
    '{32'h8006_1804, 3'h2, 32'h0006_1805, 32'h3333_3333},
    '{32'h8008_0000, 3'h2, 32'h0008_0001, 32'h3333_3333},
    '{32'h8009_0000, 3'h1, 32'h0009_0001, 32'h2222_2222},
    '{32'h8004_4008, 3'h1, 32'h0004_4009, 32'h2222_2222},
    '{32'h0005_0000, 3'h3, 32'h0000_0cfc, 32'h4444_4444}};

  cfgdec_top cfgdec_top_inst (.clk_sys, .rstn, .io_req, .io_wr, .io_addr, .io_be, .io_wdata, .io_ack,
    .io_rdata, .sec_bus, .sub_bus, .cyc_wr, .cyc_be, .cyc_wdata, .int_req, .int_dev, .int_reg, .int_ack,
    .int_rdata, .hl_req, .hl_addr, .hl_ack, .hl_rdata, .gp_req, .gp_addr, .gp_ack, .gp_rdata, .gp_mabort,
    .pio_req, .pio_addr, .pio_ack, .pio_rdata);
  // targets answer at different speeds; each one's data follows from its delay
  cfgdec_target_model #(.DLY(0)) int_model_inst (.clk_sys, .rstn, .req(int_req),
    .ack(int_ack), .rdata(int_rdata));
  cfgdec_target_model #(.DLY(1)) hl_model_inst (.clk_sys, .rstn, .req(hl_req),
    .ack(hl_ack), .rdata(hl_rdata));
  cfgdec_target_model #(.DLY(2)) gp_model_inst (.clk_sys, .rstn, .req(gp_req),
    .ack(gp_ack), .rdata(gp_rdata));
  cfgdec_target_model #(.DLY(3)) pio_model_inst (.clk_sys, .rstn, .req(pio_req),
    .ack(pio_ack), .rdata(pio_rdata));

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one processor access; qualifiers stay put until the next access
  task automatic acc(input logic w, input logic [15:0] a, input logic [3:0] b, input logic [31:0] d);
    int n;
    @(negedge clk_sys);
    io_req = 1'b1;
    io_wr = w;
    io_addr = a;
    io_be = b;
    io_wdata = d;
    @(negedge clk_sys);
    io_req = 1'b0;
    kind = 3'h4;
    seen = 32'h0000_0000;
    n = 0;
    // bounded wait so a lost answer cannot hang the run
    while (io_ack !== 1'b1 && n < 50)
    begin
      if (int_req === 1'b1)
      begin
        kind = 3'h0;
        seen = {21'h00_0000, int_dev, int_reg};
      end
      if (hl_req === 1'b1)
      begin
        kind = 3'h1;
        seen = {8'h00, hl_addr};
      end
      if (gp_req === 1'b1)
      begin
        kind = 3'h2;
        seen = gp_addr;
      end
      if (pio_req === 1'b1)
      begin
        kind = 3'h3;
        seen = {16'h0000, pio_addr};
      end
      @(negedge clk_sys);
      n++;
    end
    chk({31'h0000_0000, io_ack}, 32'h0000_0001);
    rd = io_rdata;
    mab = gp_mabort;
  endtask

  task end_of_test;
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    end_of_test();
  end

  initial
  begin
    rstn = 1'b0;
    io_req = 1'b0;
    io_wr = 1'b0;
    io_addr = 16'h0000;
    io_be = 4'h0;
    io_wdata = 32'h0000_0000;
    sec_bus = 8'h05;
    sub_bus = 8'h08;
    repeat (10) @(negedge clk_sys);
    rstn = 1'b1;
    // selector comes up disabled and cleared
    acc(1'b0, CFGDEC_SEL_ADDR, 4'hf, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    for (int i = 0; i < 11; i++)
    begin
      acc(1'b1, CFGDEC_SEL_ADDR, 4'hf, rows[i].sel);
      acc(1'b0, CFGDEC_SEL_ADDR, 4'hf, 32'h0000_0000);
      chk(rd, rows[i].sel & CFGDEC_SEL_MASK);
      acc(1'b0, CFGDEC_WIN_ADDR, 4'hf, 32'h0000_0000);
      chk({29'h0000_0000, kind}, {29'h0000_0000, rows[i].kind});
      chk(seen, rows[i].addr);
      chk(rd, rows[i].rd);
    end
    // word write to the selector address passes through as plain i/o
    acc(1'b1, CFGDEC_SEL_ADDR, 4'h3, 32'h8000_0000);
    chk(seen, 32'h0000_0cf8);
    acc(1'b0, CFGDEC_SEL_ADDR, 4'hf, 32'h0000_0000);
    chk(rd, 32'h0005_0000);
    // window write carries data and byte enables to the hub link
    acc(1'b1, CFGDEC_SEL_ADDR, 4'hf, 32'h8009_0000);
    acc(1'b1, CFGDEC_WIN_ADDR, 4'h6, 32'hdead_beef);
    chk({29'h0000_0000, kind}, 32'h0000_0001);
    chk(cyc_wdata, 32'hdead_beef);
    chk({27'h000_0000, cyc_wr, cyc_be}, 32'h0000_0016);
    // device 16 on the secondary bus: no idsel, master abort recorded
    acc(1'b1, CFGDEC_SEL_ADDR, 4'hf, 32'h8005_8000);
    acc(1'b0, CFGDEC_WIN_ADDR, 4'hf, 32'h0000_0000);
    chk(seen, 32'h0000_0000);
    chk(rd, 32'hffff_ffff);
    chk({31'h0000_0000, mab}, 32'h0000_0001);
    // graphics bridge renumbered: bus 10 is now the secondary, bus 6 falls to the hub link
    sec_bus = 8'h0a;
    sub_bus = 8'h0a;
    acc(1'b1, CFGDEC_SEL_ADDR, 4'hf, 32'h800a_0800);
    acc(1'b0, CFGDEC_WIN_ADDR, 4'hf, 32'h0000_0000);
    chk(seen, 32'h0002_0000);
    acc(1'b1, CFGDEC_SEL_ADDR, 4'hf, 32'h8006_1804);
    acc(1'b0, CFGDEC_WIN_ADDR, 4'hf, 32'h0000_0000);
    chk(seen, 32'h0006_1805);
    chk({29'h0000_0000, kind}, 32'h0000_0001);
    // mid-run reset drops every request and clears the selector
    rstn = 1'b0;
    @(negedge clk_sys);
    chk({27'h000_0000, io_ack, int_req, hl_req, gp_req, pio_req}, 32'h0000_0000);
    chk(io_rdata, 32'h0000_0000);
    rstn = 1'b1;
    acc(1'b0, CFGDEC_SEL_ADDR, 4'hf, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    end_of_test();
  end
endmodule
